// ---- tick_counter_pkg.sv ----
// package: constants and types for the low power tick counter
package tick_counter_pkg;
  localparam int count_w = 24;
  localparam int div_w = 12;
  localparam int num_match = 4;
  localparam logic [23:0] count_reset = 24'h000000;
  localparam logic [23:0] count_all_ones = 24'hffffff;
  localparam logic [23:0] near_wrap_value = 24'hfffff0;
  localparam logic [11:0] div_reset = 12'h000;
  localparam logic [11:0] div_zero = 12'h000;
  // slow clock frequency in kHz; rate = slow_khz / (div + 1)
  localparam real slow_khz = 32.768;
  // fast clock period and counter read bound
  localparam real clk_period_ns = 5.0;
  localparam int read_max_cycles = 6;
  localparam logic [2:0] read_wait_cycles = 3'h3;
  typedef enum logic [1:0] {rd_idle, rd_sync, rd_hold, rd_done} read_state_t;
endpackage : tick_counter_pkg

// ---- edge_sync.sv ----
// two-flop synchroniser with edge detect for the slow clock
`timescale 1ns/1ps
module edge_sync
  import tick_counter_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous level
  input wire logic level_in,
  // synchronised outputs
  output logic level_out,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } sync_state_t;
  sync_state_t s;
  sync_state_t next_s;
  always_comb begin
    next_s = s;
    next_s.meta = level_in;
    next_s.sync = s.meta;
    next_s.last = s.sync;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign level_out = s.sync;
  assign rise = s.sync & ~s.last;
  assign fall = ~s.sync & s.last;
endmodule : edge_sync

// ---- low_power_tick_counter.sv ----
// low power tick counter core, slow clock sampled on the fast clock
`timescale 1ns/1ps
// Function
// - 24-bit counter via 12-bit divider, match registers, periodic tick event
// - counter rate is slow clock divided by divider plus one
// - start, clear, force tasks latch divider into down counter
// - increment when down counter is zero, then reload from setting
// - tick event on every increment when enabled
// - starting requests slow clock from RC source if not running
// - counter read stalls bus, completes within six fast cycles
// - wrap event when counter goes from all ones to zero
// - force task loads counter with 0xfffff0
// - wrap and tick events disabled after reset
// - each event individually enabled; disabled events request no clocks
// - match event when counter increments onto match value
// - clear does not raise match for match value zero
// - start at counter equal to match value raises no match
// - writing N+2 or more guarantees match; N or N+1 may miss
// - old match value above N+2 never matches after rewrite
// - clear, force take effect after falling then rising slow edge; stop clears run at once
// - stop suppresses events at once; counter may step once more
// - first increment divider plus one slow periods after start takes effect on a slow rise
// - visible count latched on each read
module low_power_tick_counter
  import tick_counter_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // slow clock pin and request
  input wire logic slow_clock,
  input wire logic slow_clock_running,
  output logic slow_clock_request,
  output logic fast_clock_request,
  // tasks, one-cycle pulses
  input wire logic task_start,
  input wire logic task_stop,
  input wire logic task_clear,
  input wire logic force_near_wrap_task,
  // configuration
  input wire logic [11:0] divider_setting,
  input wire logic [23:0] match_value_0,
  input wire logic [23:0] match_value_1,
  input wire logic [23:0] match_value_2,
  input wire logic [23:0] match_value_3,
  input wire logic [5:0] event_route_enable,
  input wire logic [5:0] irq_enable,
  // sticky event flags, write one to clear, any bits at once
  input wire logic [5:0] event_clear,
  output logic [5:0] event_flags,
  output logic [5:0] event_pulse,
  output logic irq,
  // counter read port
  input wire logic read_req,
  output logic read_stall,
  output logic read_valid,
  output logic [23:0] read_data,
  // status
  output logic running
);
  // event bit order: 0 tick, 1 wrap, 2..5 match 0..3
  typedef struct packed {
    logic run;
    logic start_pend;
    logic stop_pend;
    logic clear_pend;
    logic force_pend;
    logic seen_fall;
    logic [11:0] internal_divider_count;
    logic [23:0] count;
    logic [5:0] flags;
    logic [5:0] pulse;
    read_state_t rd;
    logic [2:0] rd_cnt;
    logic [23:0] rd_data;
  } state_t;

  state_t s;
  state_t next_s;
  logic slow_level;
  logic slow_rise;
  logic slow_fall;
  logic [23:0] match_arr [num_match];
  logic [5:0] raw_ev;
  logic [23:0] next_count;
  logic step;

  function automatic logic [23:0] inc24(input logic [23:0] v);
    inc24 = v + 24'h000001;
  endfunction : inc24

  edge_sync u_slow_sync (
    .clk(clk),
    .rst_n(rst_n),
    .level_in(slow_clock),
    .level_out(slow_level),
    .rise(slow_rise),
    .fall(slow_fall)
  );

  assign match_arr[0] = match_value_0;
  assign match_arr[1] = match_value_1;
  assign match_arr[2] = match_value_2;
  assign match_arr[3] = match_value_3;

  // ----------------------------------------
  // counter and task sequencing
  // ----------------------------------------
  always_comb begin
    next_s = s;
    raw_ev = '0;
    step = 1'b0;
    next_count = s.count;
    next_s.pulse = '0;
    if (task_start) begin
      next_s.start_pend = 1'b1;
    end
    if (task_stop) begin
      next_s.stop_pend = 1'b1;
      next_s.start_pend = 1'b0;
      next_s.run = 1'b0;
    end
    if (task_clear) begin
      next_s.clear_pend = 1'b1;
    end
    if (force_near_wrap_task) begin
      next_s.force_pend = 1'b1;
    end
    if (task_stop | task_clear | force_near_wrap_task) begin
      next_s.seen_fall = 1'b0;
    end else if (slow_fall) begin
      next_s.seen_fall = 1'b1;
    end
    if (slow_rise) begin
      if (s.start_pend && !task_stop) begin
        next_s.run = 1'b1;
        next_s.start_pend = 1'b0;
        next_s.internal_divider_count = divider_setting;
      end else if (s.run && !s.stop_pend) begin
        if (s.internal_divider_count == div_zero) begin
          step = 1'b1;
          next_count = inc24(s.count);
          next_s.internal_divider_count = divider_setting;
        end else begin
          next_s.internal_divider_count = s.internal_divider_count - 12'h001;
        end
      end
      if (s.seen_fall) begin
        if (s.clear_pend) begin
          next_count = count_reset;
          next_s.internal_divider_count = divider_setting;
          step = 1'b0;
          next_s.clear_pend = 1'b0;
        end
        if (s.force_pend) begin
          next_count = near_wrap_value;
          next_s.internal_divider_count = divider_setting;
          step = 1'b0;
          next_s.force_pend = 1'b0;
        end
        if (s.stop_pend) begin
          next_s.stop_pend = 1'b0;
        end
        next_s.seen_fall = 1'b0;
      end
    end
    next_s.count = next_count;
    // events only on increment, never on clear, force or start
    if (step && s.run && !task_stop) begin
      raw_ev[0] = 1'b1;
      raw_ev[1] = (s.count == count_all_ones);
      for (int i = 0; i < num_match; i++) begin
        raw_ev[2 + i] = (next_count == match_arr[i]);
      end
    end
    next_s.pulse = raw_ev & event_route_enable;
    // set wins over clear
    next_s.flags = (s.flags & ~event_clear) | raw_ev;
    // counter read: wait for slow edge settling, then latch
    case (s.rd)
      rd_idle: begin
        if (read_req) begin
          next_s.rd = rd_sync;
          next_s.rd_cnt = '0;
        end
      end
      rd_sync: begin
        next_s.rd_cnt = s.rd_cnt + 3'h1;
        if (s.rd_cnt == read_wait_cycles) begin
          next_s.rd = rd_hold;
        end
      end
      rd_hold: begin
        next_s.rd_data = s.count;
        next_s.rd = rd_done;
      end
      rd_done: begin
        next_s.rd = rd_idle;
      end
      default: begin
        next_s.rd = rd_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign event_flags = s.flags;
  assign event_pulse = s.pulse;
  assign irq = |(s.flags & irq_enable);
  assign read_stall = (s.rd != rd_idle) && (s.rd != rd_done);
  assign read_valid = (s.rd == rd_done);
  assign read_data = s.rd_data;
  assign running = s.run;
  assign slow_clock_request = s.run | (s.start_pend & ~slow_clock_running);
  assign fast_clock_request = |(raw_ev & event_route_enable);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  logic cut_now;
  logic plain_step;
  assign cut_now = slow_rise && s.seen_fall && (s.clear_pend || s.force_pend);
  assign plain_step = slow_rise && s.run && !s.start_pend && !s.stop_pend && (s.internal_divider_count == div_zero);

  AST_READ_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
    (s.rd == rd_idle && read_req) |-> ##[1:6] read_valid)
    else $error("counter read exceeds six cycles");
  AST_FORCE_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
    (slow_rise && s.seen_fall && s.force_pend) |=> (s.count == near_wrap_value))
    else $error("force task did not load near wrap value");
  AST_WRAP_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
    (raw_ev[1]) |=> (s.count == count_reset))
    else $error("wrap event without wrap to zero");
  AST_STOP_SILENCE: assert property (@(posedge clk) disable iff (!rst_n)
    (task_stop) |=> (s.pulse == '0) [*2])
    else $error("event after stop");
  AST_TICK_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    (s.pulse[0]) |-> (s.count == $past(s.count) + 24'h000001))
    else $error("tick without increment");
  AST_DISABLED_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
    (!$past(event_route_enable[1])) |-> !s.pulse[1])
    else $error("disabled wrap event routed");
  AST_CLEAR_NO_MATCH: assert property (@(posedge clk) disable iff (!rst_n)
    (slow_rise && s.seen_fall && s.clear_pend) |=> (s.pulse[5:2] == '0))
    else $error("clear raised match event");
  AST_RESET_DISABLED: assert property (@(posedge clk)
    (!rst_n) |=> (s.pulse == '0 && !s.run))
    else $error("events active after reset");
  AST_SYNC_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
    slow_rise |=> slow_level)
    else $error("synchronised slow level dropped after rise");
  AST_START_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    (slow_rise && s.start_pend && !task_stop) |=> s.run)
    else $error("start did not begin counting");
  AST_START_LATCH: assert property (@(posedge clk) disable iff (!rst_n)
    (slow_rise && s.start_pend && !task_stop) |=> (s.internal_divider_count == $past(divider_setting)))
    else $error("start did not latch divider");
  AST_STEP_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
    plain_step |=> (s.internal_divider_count == $past(divider_setting)))
    else $error("divider not reloaded on increment");
  AST_STEP_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
    (plain_step && !cut_now) |=> (s.count == $past(s.count) + 24'h000001))
    else $error("counter did not increment at zero divider");
  AST_DIV_DOWN: assert property (@(posedge clk) disable iff (!rst_n)
    (slow_rise && s.run && !s.start_pend && !s.stop_pend && (s.internal_divider_count != div_zero) && !cut_now)
    |=> (s.internal_divider_count == $past(s.internal_divider_count) - 12'h001))
    else $error("divider did not count down");
  AST_COUNT_ON_RISE: assert property (@(posedge clk) disable iff (!rst_n)
    (!slow_rise) |=> $stable(s.count))
    else $error("counter moved without slow edge");
  AST_TICK_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    raw_ev[0] |=> s.flags[0])
    else $error("tick flag not set");
  AST_WRAP_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
    raw_ev[1] |=> s.flags[1])
    else $error("wrap flag not set");
  AST_MATCH_VALUE: assert property (@(posedge clk) disable iff (!rst_n)
    raw_ev[2] |=> (s.count == $past(match_value_0)))
    else $error("match event at wrong count");
  AST_MATCH_ON_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    (raw_ev[5:2] != 4'h0) |-> raw_ev[0])
    else $error("match event without increment");
  AST_FORCE_SILENT: assert property (@(posedge clk) disable iff (!rst_n)
    (slow_rise && s.seen_fall && s.force_pend) |=> (s.pulse == 6'h00))
    else $error("force task raised an event");
  AST_CLEAR_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    (slow_rise && s.seen_fall && s.clear_pend && !s.force_pend) |=> (s.count == count_reset))
    else $error("clear did not zero counter");
  AST_CLEAR_WAITS: assert property (@(posedge clk) disable iff (!rst_n)
    (s.clear_pend && !(slow_rise && s.seen_fall)) |=> s.clear_pend)
    else $error("clear applied before slow edges");
  AST_STOP_HALTS: assert property (@(posedge clk) disable iff (!rst_n)
    task_stop |=> !s.run)
    else $error("still running after stop");
  AST_STOPPED_NO_EVENT: assert property (@(posedge clk) disable iff (!rst_n)
    (!s.run) |-> (raw_ev == 6'h00))
    else $error("event while stopped");
  AST_TICK_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
    s.pulse[0] |=> !s.pulse[0])
    else $error("tick pulse longer than one cycle");
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    (s.flags[1] && !event_clear[1]) |=> s.flags[1])
    else $error("wrap flag lost without clear");
  AST_FLAG_CLEARED: assert property (@(posedge clk) disable iff (!rst_n)
    (event_clear[0] && !raw_ev[0]) |=> !s.flags[0])
    else $error("tick flag not cleared");
  AST_REQ_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    s.run |-> slow_clock_request)
    else $error("slow clock not requested while running");
  AST_REQ_START: assert property (@(posedge clk) disable iff (!rst_n)
    (s.start_pend && !slow_clock_running) |-> slow_clock_request)
    else $error("slow clock not requested on start");
  AST_FAST_REQ: assert property (@(posedge clk) disable iff (!rst_n)
    fast_clock_request |=> (s.pulse != 6'h00))
    else $error("fast clock requested without event");
  AST_READ_STALL: assert property (@(posedge clk) disable iff (!rst_n)
    (s.rd == rd_idle && read_req) |=> read_stall [*5] ##1 read_valid)
    else $error("read stall sequence wrong");
  AST_READ_DATA: assert property (@(posedge clk) disable iff (!rst_n)
    read_valid |-> (read_data == $past(s.count)))
    else $error("read data not latched from count");
  AST_VALID_ONE: assert property (@(posedge clk) disable iff (!rst_n)
    read_valid |=> !read_valid)
    else $error("read valid longer than one cycle");
  AST_RUN_FROM_START: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(s.run) |-> ($past(s.start_pend) && $past(slow_rise)))
    else $error("running without start on slow edge");
  AST_STOP_PEND_NO_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    s.stop_pend |-> !step)
    else $error("increment while stop pending");
endmodule : low_power_tick_counter

// ---- low_power_tick_counter_tb.sv ----
// self-checking testbench for the low power tick counter
`timescale 1ns/1ps
module low_power_tick_counter_tb import tick_counter_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow_clock = 1'b0;
  logic slow_clock_running = 1'b0;
  logic task_start = 1'b0;
  logic task_stop = 1'b0;
  logic task_clear = 1'b0;
  logic force_near_wrap_task = 1'b0;
  logic [11:0] divider_setting = 12'h000;
  logic [23:0] match_value_0 = 24'h000000;
  logic [23:0] match_value_1 = 24'h000003;
  logic [5:0] event_route_enable = 6'h00;
  logic [5:0] irq_enable = 6'h00;
  logic [5:0] event_clear = 6'h00;
  logic read_req = 1'b0;
  logic slow_clock_request;
  logic fast_clock_request;
  logic irq;
  logic read_stall;
  logic read_valid;
  logic running;
  logic [5:0] event_flags;
  logic [5:0] event_pulse;
  logic [23:0] read_data;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int n;
  int k;
  int m;

  low_power_tick_counter DUT (
    .clk, .rst_n, .slow_clock, .slow_clock_running, .slow_clock_request, .fast_clock_request,
    .task_start, .task_stop, .task_clear, .force_near_wrap_task, .divider_setting,
    .match_value_0, .match_value_1, .match_value_2(24'h800000), .match_value_3(24'h800000),
    .event_route_enable, .irq_enable, .event_clear, .event_flags, .event_pulse, .irq,
    .read_req, .read_stall, .read_valid, .read_data, .running
  );

  // ----------------------------------------
  // clocks and timeout
  // ----------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    forever begin
      repeat (20) @(posedge clk);
      #1 slow_clock = ~slow_clock;
    end
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task step(input int c);
    repeat (c) begin
      @(posedge clk);
      #1;
    end
  endtask : step
  task chk(input logic [23:0] s, input logic [23:0] e);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task rd_cnt();
    read_req = 1'b1;
    step(1);
    read_req = 1'b0;
    chk(24'(read_stall), 24'h1);
    n = 0;
    while (read_valid !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    chk(24'(n), 24'h5);
  endtask : rd_cnt
  task wait_pulse(input int b);
    n = 0;
    do begin
      step(1);
      n++;
    end while (event_pulse[b] !== 1'b1 && n < 3000);
  endtask : wait_pulse
  task close_out();
    $display("compared=%0d fails=%0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    step(12);
    rst_n = 1'b1;
    step(3);
    chk(24'(event_flags), 24'h0);
    chk(24'(running), 24'h0);
    rd_cnt();
    chk(read_data, count_reset);
    divider_setting = 12'h002;
    event_route_enable = 6'h3f;
    irq_enable = 6'h01;
    task_start = 1'b1;
    slow_clock_running = 1'b1;
    step(1);
    task_start = 1'b0;
    chk(24'(slow_clock_request), 24'h0);
    slow_clock_running = 1'b0;
    step(1);
    chk(24'(slow_clock_request), 24'h1);
    wait_pulse(0);
    chk(24'(running), 24'h1);
    chk(24'(irq), 24'h1);
    wait_pulse(0);
    chk(24'(n), 24'd120);
    wait_pulse(3);
    chk(24'(n), 24'd120);
    chk(24'(event_flags[2]), 24'h0);
    event_clear = 6'h01;
    step(1);
    event_clear = 6'h3f;
    chk(24'(irq), 24'h0);
    step(1);
    event_clear = 6'h00;
    task_clear = 1'b1;
    step(1);
    task_clear = 1'b0;
    step(100);
    chk(24'(event_flags[2]), 24'h0);
    rd_cnt();
    chk(read_data, count_reset);
    task_stop = 1'b1;
    step(1);
    task_stop = 1'b0;
    k = 0;
    repeat (300) begin
      if (event_pulse !== 6'h00) k++;
      step(1);
    end
    chk(24'(k), 24'h0);
    chk(24'(running), 24'h0);
    divider_setting = 12'h000;
    force_near_wrap_task = 1'b1;
    step(1);
    force_near_wrap_task = 1'b0;
    step(100);
    rd_cnt();
    chk(read_data, near_wrap_value);
    task_start = 1'b1;
    step(1);
    task_start = 1'b0;
    k = 0;
    m = 0;
    n = 0;
    do begin
      step(1);
      n++;
      if (event_pulse[0] === 1'b1) k++;
      if (fast_clock_request === 1'b1) m++;
    end while (event_pulse[1] !== 1'b1 && n < 3000);
    chk(24'(k), 24'd16);
    chk(24'(m), 24'd16);
    rd_cnt();
    chk(read_data, count_reset);
    event_route_enable = 6'h00;
    k = 0;
    repeat (200) begin
      if (event_pulse !== 6'h00 || fast_clock_request !== 1'b0) k++;
      step(1);
    end
    chk(24'(k), 24'h0);
    close_out();
  end
endmodule : low_power_tick_counter_tb
